/* File: src/ssm_params.svh */
// Register offsets, field positions, reset values and timing counts of the supervisor block
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

`define SSM_ADDR_W 8
`define SSM_OFF_HCTL 8'h00
`define SSM_OFF_LCTL 8'h04
`define SSM_OFF_STAT 8'h08
`define SSM_OFF_MASK 8'h0C
`define SSM_OFF_STATE 8'h10

`define SSM_CTL_ON 0
`define SSM_CTL_FP 1
`define SSM_CTL_KEEP 2
`define SSM_CTL_RST 3
`define SSM_CTL_MON 4
`define SSM_CTL_MFP 5
`define SSM_CTL_RESET 6'h11

`define SSM_ST_HEVT 0
`define SSM_ST_LEVT 1
`define SSM_ST_HDLY 2
`define SSM_ST_LDLY 3
`define SSM_ST_W 4

`define SSM_CLK_MHZ 125
`define SSM_FAST_NS 2000
`define SSM_SLOW_NS 150000
`define SSM_FAST_CYC ((`SSM_FAST_NS * `SSM_CLK_MHZ + 999) / 1000)
`define SSM_SLOW_CYC ((`SSM_SLOW_NS * `SSM_CLK_MHZ + 999) / 1000)
`define SSM_CNT_W 15

`endif

/* File: src/ssm_pkg.sv */
// Types shared by the supervisor block
package ssm_pkg;
  typedef enum logic [1:0] {
    SSM_IDLE = 2'b00,
    SSM_MASK = 2'b01
  } ssm_mask_t;
endpackage

/* File: src/ssm_mask_timer.sv */
// Event masking timer for one supervisor comparator
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_mask_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [`SSM_CNT_W-1:0] load,
  output logic busy,
  output logic done
);
  logic [`SSM_CNT_W-1:0] cnt_q;
  ssm_pkg::ssm_mask_t st_q;

  assign busy = (st_q == ssm_pkg::SSM_MASK);
  assign done = busy && (cnt_q == `SSM_CNT_W'(1)) && !start;

  // Restart on every start pulse, count down to the end of masking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ssm_pkg::SSM_IDLE;
      cnt_q <= '0;
    end else if (start) begin
      st_q <= ssm_pkg::SSM_MASK;
      cnt_q <= load;
    end else if (busy) begin
      cnt_q <= cnt_q - `SSM_CNT_W'(1);
      if (cnt_q == `SSM_CNT_W'(1)) begin
        st_q <= ssm_pkg::SSM_IDLE;
      end
    end
  end
endmodule // ssm_mask_timer

/* File: src/ssm_supervisor.sv */
// Supply supervisor control: masking delays, flags, reset, pin hold-off, AXI4-Lite slave
// How it works
// - Full-performance enable or re-enable masks comparator events for 2 us.
// - Normal low side holds CPU 150 us after deep-sleep wakeup.
// - Low side both off or both full-performance: wakeup mask lasts 2 us.
// - Comparator event sets side flag; reset-enable also raises power-on reset.
// - Any event flag set tri-states all GPIO until comparators settle.
// - Keep-on bit 0 turns comparator off in deep sleep, on at wake.
// - Keep-on bit 1 leaves main comparator powered through deep sleep; low monitor comparator still turns off.
// - Performance-select 1 picks full-performance mode, 0 picks normal.
// - After soft or power-on reset both supervisors are switched on.
// - Supervisor off before soft reset: flags stay inactive until control written.
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_supervisor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset_clear,
  input wire logic deep_sleep_states,
  input wire logic high_comp_trip,
  input wire logic low_comp_trip,
  output logic high_comp_on,
  output logic low_comp_on,
  output logic low_monitor_comp_on,
  output logic high_full_perf,
  output logic low_full_perf,
  output logic por_request,
  output logic gpio_tristate,
  output logic cpu_hold,
  output logic irq,
  input wire logic [`SSM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SSM_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [`SSM_CNT_W-1:0] FAST_LOAD = `SSM_CNT_W'(`SSM_FAST_CYC);
  localparam logic [`SSM_CNT_W-1:0] SLOW_LOAD = `SSM_CNT_W'(`SSM_SLOW_CYC);

  logic [5:0] hctl_q;
  logic [5:0] lctl_q;
  logic [`SSM_ST_W-1:0] stat_q;
  logic [`SSM_ST_W-1:0] stat_d;
  logic [`SSM_ST_W-1:0] mask_q;
  logic hrep_q;
  logic lrep_q;
  logic sleep_q;
  logic hon_q;
  logic lon_q;
  logic hfp_q;
  logic lfp_q;
  logic lmon_q;
  logic lmfp_q;
  logic [`SSM_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Write channel capture: address and data accepted in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_full = aw_have_q || aw_hs;
  wire w_full = w_have_q || w_hs;
  wire [`SSM_ADDR_W-1:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = aw_full && w_full && !bvalid_q;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire wr_hctl = wr_go && (wr_addr == `SSM_OFF_HCTL);
  wire wr_lctl = wr_go && (wr_addr == `SSM_OFF_LCTL);
  wire wr_stat = wr_lane0 && (wr_addr == `SSM_OFF_STAT);
  wire wr_mask = wr_lane0 && (wr_addr == `SSM_OFF_MASK);
  wire wr_ok = wr_hctl || wr_lctl || (wr_addr == `SSM_OFF_STAT) ||
               (wr_addr == `SSM_OFF_MASK);
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel: one cycle from address to data
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire rd_hit = (s_axi_araddr == `SSM_OFF_HCTL) || (s_axi_araddr == `SSM_OFF_LCTL) ||
                (s_axi_araddr == `SSM_OFF_STAT) || (s_axi_araddr == `SSM_OFF_MASK) ||
                (s_axi_araddr == `SSM_OFF_STATE);
  wire [31:0] state_word = {24'h000000, cpu_hold, gpio_tristate, lmfp_q, lmon_q,
                            lfp_q, lon_q, hfp_q, hon_q};
  wire [31:0] rd_mux = (s_axi_araddr == `SSM_OFF_HCTL) ? {26'h0000000, hctl_q} :
                       (s_axi_araddr == `SSM_OFF_LCTL) ? {26'h0000000, lctl_q} :
                       (s_axi_araddr == `SSM_OFF_STAT) ? {28'h0000000, stat_q} :
                       (s_axi_araddr == `SSM_OFF_MASK) ? {28'h0000000, mask_q} :
                       (s_axi_araddr == `SSM_OFF_STATE) ? state_word : 32'h00000000;

  // Bus handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_have_q <= aw_full && !wr_go;
      w_have_q <= w_full && !wr_go;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read answer register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control registers; soft reset forces both supervisors on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hctl_q <= `SSM_CTL_RESET;
      lctl_q <= `SSM_CTL_RESET;
      mask_q <= '0;
    end else if (soft_reset_clear) begin
      hctl_q[`SSM_CTL_ON] <= 1'b1;
      lctl_q[`SSM_CTL_ON] <= 1'b1;
    end else begin
      if (wr_hctl && wr_strb[0]) begin
        hctl_q <= wr_data[5:0];
      end
      if (wr_lctl && wr_strb[0]) begin
        lctl_q <= wr_data[5:0];
      end
      if (wr_mask) begin
        mask_q <= wr_data[`SSM_ST_W-1:0];
      end
    end
  end

  // Flag reporting: lost when a supervisor was off at soft reset, back on control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hrep_q <= 1'b1;
      lrep_q <= 1'b1;
    end else if (soft_reset_clear) begin
      hrep_q <= hrep_q && hctl_q[`SSM_CTL_ON];
      lrep_q <= lrep_q && lctl_q[`SSM_CTL_ON];
    end else begin
      hrep_q <= hrep_q || wr_hctl;
      lrep_q <= lrep_q || wr_lctl;
    end
  end

  // Effective comparator power and mode, with automatic sleep switching
  wire h_on_d = hctl_q[`SSM_CTL_ON] && (!deep_sleep_states || hctl_q[`SSM_CTL_KEEP]);
  wire l_on_d = lctl_q[`SSM_CTL_ON] && (!deep_sleep_states || lctl_q[`SSM_CTL_KEEP]);
  wire lm_on_d = lctl_q[`SSM_CTL_MON] && !deep_sleep_states;
  wire h_fp_d = hctl_q[`SSM_CTL_FP];
  wire l_fp_d = lctl_q[`SSM_CTL_FP];
  wire lm_fp_d = lctl_q[`SSM_CTL_MFP];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {hon_q, lon_q, lmon_q, hfp_q, lfp_q, lmfp_q} <= 6'h00;
      sleep_q <= 1'b0;
    end else begin
      {hon_q, lon_q, lmon_q} <= {h_on_d, l_on_d, lm_on_d};
      {hfp_q, lfp_q, lmfp_q} <= {h_fp_d, l_fp_d, lm_fp_d};
      sleep_q <= deep_sleep_states;
    end
  end
  assign high_comp_on = hon_q;
  assign low_comp_on = lon_q;
  assign low_monitor_comp_on = lmon_q;
  assign high_full_perf = hfp_q;
  assign low_full_perf = lfp_q;

  // Restart masking when a comparator turns on or changes mode; soft reset counts too
  wire h_start = (h_on_d && (!hon_q || h_fp_d != hfp_q)) ||
                 (soft_reset_clear && hrep_q);
  wire l_start = (l_on_d && (!lon_q || l_fp_d != lfp_q)) ||
                 (soft_reset_clear && lrep_q);
  wire [`SSM_CNT_W-1:0] h_load = h_fp_d ? FAST_LOAD : SLOW_LOAD;
  wire [`SSM_CNT_W-1:0] l_load = l_fp_d ? FAST_LOAD : SLOW_LOAD;
  wire h_busy;
  wire l_busy;
  wire h_done;
  wire l_done;
  ssm_mask_timer u_high_mask (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(h_start),
    .load(h_load),
    .busy(h_busy),
    .done(h_done)
  );
  ssm_mask_timer u_low_mask (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(l_start),
    .load(l_load),
    .busy(l_busy),
    .done(l_done)
  );

  // Wakeup execution hold: slow unless low side is off or fully fast
  wire wake = sleep_q && !deep_sleep_states;
  wire low_fast = (!lctl_q[`SSM_CTL_ON] && !lctl_q[`SSM_CTL_MON]) ||
                  (lctl_q[`SSM_CTL_FP] && lctl_q[`SSM_CTL_MFP]);
  wire [`SSM_CNT_W-1:0] w_load = low_fast ? FAST_LOAD : SLOW_LOAD;
  wire w_busy;
  ssm_mask_timer u_wake_mask (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wake),
    .load(w_load),
    .busy(w_busy),
    .done()
  );
  assign cpu_hold = w_busy || wake;

  // Events pass only when comparator is on and not masked
  wire h_evt = high_comp_trip && hon_q && !h_busy && hrep_q;
  wire l_evt = low_comp_trip && lon_q && !l_busy && lrep_q;

  // Sticky status, write one to clear, set wins over clear
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wr_data[`SSM_ST_W-1:0];
    end
    if (h_evt) begin
      stat_d[`SSM_ST_HEVT] = 1'b1;
    end
    if (l_evt) begin
      stat_d[`SSM_ST_LEVT] = 1'b1;
    end
    if (h_done) begin
      stat_d[`SSM_ST_HDLY] = 1'b1;
    end
    if (l_done) begin
      stat_d[`SSM_ST_LDLY] = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Power-on reset request from an event with reset enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_request <= 1'b0;
    end else begin
      por_request <= (h_evt && hctl_q[`SSM_CTL_RST]) || (l_evt && lctl_q[`SSM_CTL_RST]);
    end
  end

  // Pins float while an event flag stands and a comparator is still settling
  assign gpio_tristate = (stat_q[`SSM_ST_HEVT] || stat_q[`SSM_ST_LEVT]) &&
                         (h_busy || l_busy || h_evt || l_evt);
  assign irq = |(stat_q & mask_q);
endmodule // ssm_supervisor

/* File: test/ssm_supervisor_assertions.sv */
// Port-level checks for the supervisor block
`timescale 1ns/1ps
module ssm_supervisor_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset_clear,
  input wire logic deep_sleep_states,
  input wire logic high_comp_trip,
  input wire logic low_comp_trip,
  input wire logic high_comp_on,
  input wire logic low_comp_on,
  input wire logic por_request,
  input wire logic gpio_tristate,
  input wire logic cpu_hold,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] hold_q;
  // Length of the current wakeup hold
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_q <= 16'h0000;
    else hold_q <= cpu_hold ? hold_q + 16'h0001 : 16'h0000;
  end
  por_cause_a: assert property (
    por_request |-> $past(high_comp_trip) || $past(low_comp_trip))
    else $error("reset request without event");
  tri_state_a: assert property (
    por_request && (high_comp_trip || low_comp_trip) |-> gpio_tristate)
    else $error("pins not released during event");
  wake_hold_a: assert property (
    $fell(deep_sleep_states) |-> ##[0:2] cpu_hold)
    else $error("no hold after wakeup");
  hold_cause_a: assert property (
    $rose(cpu_hold) |-> !deep_sleep_states)
    else $error("hold raised while asleep");
  hold_len_a: assert property (
    $fell(cpu_hold) |-> hold_q inside {[250:252], [18750:18752]})
    else $error("wakeup hold length wrong");
  soft_on_a: assert property (
    soft_reset_clear && !deep_sleep_states |-> ##[1:2] (high_comp_on && low_comp_on))
    else $error("comparators not on after soft reset");
  mask_quiet_a: assert property (
    $rose(high_comp_on) && $rose(low_comp_on) |=> !por_request [*8])
    else $error("event passed during masking");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  cover property (por_request);
  cover property (cpu_hold ##1 !cpu_hold);
  cover property (soft_reset_clear);
endmodule // ssm_supervisor_chk

bind ssm_supervisor ssm_supervisor_chk u_chk (.*);

/* File: test/ssm_supervisor_tb_top.sv */
// Self-checking bench for the supervisor block
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_supervisor_tb_top;
  logic aclk, aresetn, soft_reset_clear, deep_sleep_states, high_comp_trip, low_comp_trip;
  logic high_comp_on, low_comp_on, low_monitor_comp_on, high_full_perf, low_full_perf;
  logic por_request, gpio_tristate, cpu_hold, irq;
  logic [`SSM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, s;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares, check_count, cyc;

  ssm_supervisor dut (.*);

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      end_sim;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks=%0d bad=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Register write, both channels offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  // Register read; rready comes late on purpose
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // Comparator event held for three cycles; returns {reset request, pins released}
  task trip(input logic h, input logic l);
    s = 2'b00;
    high_comp_trip <= h;
    low_comp_trip <= l;
    repeat (3) begin
      @(posedge aclk);
      s = s | {por_request, gpio_tristate};
    end
    high_comp_trip <= 1'b0;
    low_comp_trip <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // Sleep and wake, then measure the CPU hold
  task nap(input logic [1:0] on, input int exp);
    int n;
    n = 0;
    deep_sleep_states <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({high_comp_on, low_comp_on}, on);
    chk(low_monitor_comp_on, 1'b0);
    deep_sleep_states <= 1'b0;
    repeat (2) @(posedge aclk);
    while (cpu_hold === 1'b1) begin
      n++;
      @(posedge aclk);
    end
    chk((n >= exp - 2) && (n <= exp), 1'b1);
  endtask

  task t_reset;
    rd(`SSM_OFF_HCTL, 32'h00000011, 2'h0);
    rd(`SSM_OFF_LCTL, 32'h00000011, 2'h0);
    rd(`SSM_OFF_MASK, 32'h00000000, 2'h0);
    rd(`SSM_OFF_STATE, 32'h00000015, 2'h0);
    rd(8'h20, 32'h00000000, 2'h2);
    wr(8'h20, 32'h00000000, 2'h2);
    repeat (18760) @(posedge aclk);
    rd(`SSM_OFF_STAT, 32'h0000000C, 2'h0);
    wr(`SSM_OFF_STAT, 32'h0000000F, 2'h0);
    rd(`SSM_OFF_STAT, 32'h00000000, 2'h0);
    $display("reset test done");
  endtask

  task t_event;
    wr(`SSM_OFF_HCTL, 32'h00000019, 2'h0);
    wr(`SSM_OFF_MASK, 32'h00000001, 2'h0);
    trip(1'b1, 1'b0);
    chk(s, 2'b11);
    chk(irq, 1'b1);
    rd(`SSM_OFF_STAT, 32'h00000001, 2'h0);
    wr(`SSM_OFF_STAT, 32'h00000001, 2'h0);
    chk(irq, 1'b0);
    trip(1'b0, 1'b1);
    chk(s[1], 1'b0);
    chk(irq, 1'b0);
    rd(`SSM_OFF_STAT, 32'h00000002, 2'h0);
    wr(`SSM_OFF_STAT, 32'h00000002, 2'h0);
    // Mode switch to full performance restarts the short mask: early trip lost, late one taken
    wr(`SSM_OFF_HCTL, 32'h0000001B, 2'h0);
    repeat (2) @(posedge aclk);
    chk(high_full_perf, 1'b1);
    trip(1'b1, 1'b0);
    chk(s, 2'b00);
    repeat (`SSM_FAST_CYC) @(posedge aclk);
    trip(1'b1, 1'b0);
    chk(s, 2'b11);
    rd(`SSM_OFF_STAT, 32'h00000005, 2'h0);
    wr(`SSM_OFF_STAT, 32'h0000000F, 2'h0);
    chk(irq, 1'b0);
    $display("event test done");
  endtask

  task t_wake;
    wr(`SSM_OFF_LCTL, 32'h00000033, 2'h0);
    repeat (2) @(posedge aclk);
    chk(low_full_perf, 1'b1);
    repeat (300) @(posedge aclk);
    nap(2'b00, 251);
    wr(`SSM_OFF_HCTL, 32'h00000015, 2'h0);
    wr(`SSM_OFF_LCTL, 32'h00000011, 2'h0);
    repeat (2) @(posedge aclk);
    chk(low_full_perf, 1'b0);
    repeat (18760) @(posedge aclk);
    nap(2'b10, 18751);
    $display("wake test done");
  endtask

  task t_soft;
    wr(`SSM_OFF_HCTL, 32'h00000000, 2'h0);
    repeat (2) @(posedge aclk);
    chk(high_comp_on, 1'b0);
    soft_reset_clear <= 1'b1;
    @(posedge aclk);
    soft_reset_clear <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({high_comp_on, low_comp_on}, 2'b11);
    repeat (18760) @(posedge aclk);
    wr(`SSM_OFF_STAT, 32'h0000000F, 2'h0);
    trip(1'b1, 1'b0);
    rd(`SSM_OFF_STAT, 32'h00000000, 2'h0);
    wr(`SSM_OFF_HCTL, 32'h00000001, 2'h0);
    trip(1'b1, 1'b0);
    rd(`SSM_OFF_STAT, 32'h00000001, 2'h0);
    $display("soft reset test done");
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {soft_reset_clear, deep_sleep_states, high_comp_trip, low_comp_trip} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_event;
    t_wake;
    t_soft;
    end_sim;
  end
endmodule // ssm_supervisor_tb_top
